// ===== inc/char_ram_map.svh
`ifndef CHAR_RAM_MAP_SVH
`define CHAR_RAM_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define OFS_STATUS      8'h00
`define OFS_DATA        8'h04
`define OFS_COMMAND     8'h08
`define OFS_CONFIG      8'h0c
`define OFS_SHIFT       8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_DISP_BIT    7
`define CMD_GLYPH_BIT   6
`define CFG_MODE_LSB    0
`define CFG_DOWN_BIT    2
`define CFG_ICON_BIT    3
`define CFG_BLINK_BIT   4
`define SHIFT_LEFT_BIT  0
`define STAT_BUSY_BIT   7

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define CFG_RESET       5'h00
`define MODE_CODE_2X12  2'h1
`define MODE_CODE_1X12  2'h2
`define HSIZE_WORD      3'h2

// ----------------------------------------------------------------
// timing and address geometry
// ----------------------------------------------------------------
`define OP_CYCLES       2'h3
`define LINE2_BASE      7'h40
`define END_1X24        7'h4f
`define END_LINE1       7'h27
`define END_LINE2       7'h67
`define LEN_1X24        7'h50
`define LEN_HALF        7'h28
`define SHOW_1X24       5'h18
`define SHOW_12         5'h0c
`define ICONS_BLINK     3'h6
`define ICONS_STEADY    3'h3

`endif

// ===== inc/char_ram_pkg.sv
package char_ram_pkg;

  // ----------------------------------------------------------------
  // display organisation
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {mode_1x24, mode_2x12, mode_1x12} line_mode_e;

  // which store the location counter points into
  typedef enum logic {target_display, target_glyph} target_e;

  // ----------------------------------------------------------------
  // display scan request from the row/column timing logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       line;    // 0 first line, 1 second line
    logic [4:0] column;  // character position on the line
    logic [2:0] row;     // dot row inside the glyph
  } scan_s;

endpackage : char_ram_pkg

// ===== src/char_ram_addressing.sv
// Our own choices: the AHB-Lite register port and the address map.
`include "char_ram_map.svh"

module char_ram_addressing
(
  // clock, reset, freeze
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // display scan
  input  wire char_ram_pkg::scan_s scan,
  output logic      [4:0]          scan_dots,
  // status
  output logic                     busy_indicator,
  output logic      [2:0]          icon_glyph_count
);
  import char_ram_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       dp_valid;          // data phase in progress
  logic       dp_write;          // data phase is a write
  logic [7:0] dp_addr;           // register offset of data phase
  logic       rd_done;           // read wait state already spent
  logic [1:0] busy_count;        // cycles left of current operation
  logic [6:0] location_counter;  // shared store address
  target_e    target;            // store the counter points into
  line_mode_e mode;              // line organisation
  logic       step_down;         // step direction after access
  logic       icon_on;           // icon rows driven
  logic       icon_blink;        // icons blink
  logic [6:0] shift_offset;      // display shift within a line
  logic [7:0] character_store [128];  // display codes, 7-bit index
  logic [4:0] user_glyph_store [128]; // 16 glyphs of 8 rows

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic accept;       // address phase taken
  logic wr_fire;      // write data phase ends this cycle
  logic rd_fire;      // read data is sampled this cycle
  logic data_write;   // executed data write
  logic data_read;    // executed data read
  logic cmd_write;    // executed address command
  logic cfg_write;    // executed configuration write
  logic shift_write;  // executed display shift
  logic op_start;     // any executed instruction

  assign accept = hsel & htrans[1] & hready & (hsize == `HSIZE_WORD);
  assign wr_fire = ce & dp_valid & dp_write;
  assign rd_fire = ce & dp_valid & ~dp_write & ~rd_done;

  // while busy, data accesses and command, configuration and shift writes are dropped
  assign data_write  = wr_fire & (dp_addr == `OFS_DATA) & ~busy_indicator;
  assign data_read   = rd_fire & (dp_addr == `OFS_DATA) & ~busy_indicator;
  assign cmd_write   = wr_fire & (dp_addr == `OFS_COMMAND) & ~busy_indicator;
  assign cfg_write   = wr_fire & (dp_addr == `OFS_CONFIG) & ~busy_indicator;
  assign shift_write = wr_fire & (dp_addr == `OFS_SHIFT) & ~busy_indicator;
  assign op_start = data_write | data_read | cmd_write | cfg_write | shift_write;

  // writes finish in one data cycle, reads take one wait state so
  // read data always comes from a flip-flop
  assign hreadyout = ~(dp_valid & ~dp_write & ~rd_done);
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // address and data phase tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else if (ce && hreadyout)
    begin
      dp_valid <= accept;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // wait state marker for reads
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_done <= 1'b0;
    else if (ce)
      rd_done <= rd_fire;
  end

  // ----------------------------------------------------------------
  // busy indicator
  // ----------------------------------------------------------------
  // every executed instruction holds busy for the fixed count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_count <= 2'h0;
    else if (ce)
    begin
      if (op_start)
        busy_count <= `OP_CYCLES;
      else if (busy_count != 2'h0)
        busy_count <= busy_count - 2'h1;
    end
  end

  assign busy_indicator = (busy_count != 2'h0);

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  // mode code 3 is not a mode; it falls back to one line of 24
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode       <= mode_1x24;
      step_down  <= 1'b0;
      icon_on    <= 1'b0;
      icon_blink <= 1'b0;
    end
    else if (cfg_write)
    begin
      unique case (hwdata[`CFG_MODE_LSB +: 2])
        `MODE_CODE_2X12: mode <= mode_2x12;
        `MODE_CODE_1X12: mode <= mode_1x12;
        default:         mode <= mode_1x24;
      endcase
      step_down  <= hwdata[`CFG_DOWN_BIT];
      icon_on    <= hwdata[`CFG_ICON_BIT];
      icon_blink <= hwdata[`CFG_BLINK_BIT];
    end
  end

  // glyph slots taken by icon driving
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      icon_glyph_count <= 3'h0;
    else if (ce)
      icon_glyph_count <= !icon_on ? 3'h0 :
                          icon_blink ? `ICONS_BLINK : `ICONS_STEADY;
  end

  // ----------------------------------------------------------------
  // location counter stepping
  // ----------------------------------------------------------------
  function automatic logic [6:0] step_display(
    input logic [6:0] a, input line_mode_e m, input logic dn);
    logic [6:0] r;
    r = dn ? a - 7'h01 : a + 7'h01;
    unique case (m)
      mode_2x12:
        if (!dn && a == `END_LINE1)      r = `LINE2_BASE;
        else if (!dn && a == `END_LINE2) r = 7'h00;
        else if (dn && a == `LINE2_BASE) r = `END_LINE1;
        else if (dn && a == 7'h00)       r = `END_LINE2;
      mode_1x12:
        if (!dn && a == `END_LINE1)      r = 7'h00;
        else if (dn && a == 7'h00)       r = `END_LINE1;
      mode_1x24:
        if (!dn && a == `END_1X24)       r = 7'h00;
        else if (dn && a == 7'h00)       r = `END_1X24;
    endcase
    return r;
  endfunction : step_display

  logic [6:0] next_location;  // counter after a data access

  // glyph store steps freely, so bit 6 is reached by stepping
  always_comb
  begin
    if (target == target_glyph)
      next_location = step_down ? location_counter - 7'h01
                                : location_counter + 7'h01;
    else
      next_location = step_display(location_counter, mode, step_down);
  end

  // loading by address commands, stepping after each data access
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      location_counter <= 7'h00;
      target           <= target_display;
    end
    else if (cmd_write && hwdata[`CMD_DISP_BIT])
    begin
      location_counter <= hwdata[6:0];
      target           <= target_display;
    end
    else if (cmd_write && hwdata[`CMD_GLYPH_BIT])
    begin
      location_counter <= {location_counter[6], hwdata[5:0]};
      target           <= target_glyph;
    end
    else if (data_write || data_read)
      location_counter <= next_location;
  end

  // ----------------------------------------------------------------
  // stores
  // ----------------------------------------------------------------
  // unused display locations stay plain read/write storage
  always_ff @(posedge clk)
  begin
    if (data_write && target == target_display)
      character_store[location_counter] <= hwdata[7:0];
  end

  // glyph store row index is {slot, dot row}
  always_ff @(posedge clk)
  begin
    if (data_write && target == target_glyph)
      user_glyph_store[location_counter] <= hwdata[4:0];
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] store_value;  // byte at the location counter
  logic [7:0] read_value;   // value for the addressed register

  assign store_value = (target == target_glyph)
                     ? {3'h0, user_glyph_store[location_counter]}
                     : character_store[location_counter];

  always_comb
  begin
    read_value = 8'h00;
    unique case (dp_addr)
      `OFS_STATUS: read_value = {busy_indicator, location_counter};
      `OFS_DATA:   read_value = busy_indicator ? 8'h00 : store_value;
      `OFS_CONFIG: read_value = {3'h0, icon_blink, icon_on, step_down,
                                 mode == mode_2x12, mode == mode_1x12};
      `OFS_SHIFT:  read_value = {1'b0, shift_offset};
      default:     read_value = 8'h00;  // command register and holes
    endcase
  end

  // sampled in the read wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h0000_0000;
    else if (rd_fire)
      hrdata <= {24'h00_0000, read_value};
  end

  // ----------------------------------------------------------------
  // display shift
  // ----------------------------------------------------------------
  logic [6:0] line_len;  // locations per display line

  assign line_len = (mode == mode_1x24) ? `LEN_1X24 : `LEN_HALF;

  // one offset for all lines, so every line moves together; a mode
  // change recentres to avoid an offset beyond the new line length
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_offset <= 7'h00;
    else if (cfg_write)
      shift_offset <= 7'h00;
    else if (shift_write && hwdata[`SHIFT_LEFT_BIT])
      shift_offset <= (shift_offset == line_len - 7'h01)
                      ? 7'h00 : shift_offset + 7'h01;
    else if (shift_write)
      shift_offset <= (shift_offset == 7'h00)
                      ? line_len - 7'h01 : shift_offset - 7'h01;
  end

  // ----------------------------------------------------------------
  // display scan
  // ----------------------------------------------------------------
  logic [6:0] pos_sum;     // column plus offset
  logic [6:0] pos_in_line; // wrapped within its own line
  logic [6:0] scan_addr;   // character store location shown
  logic       scan_ok;     // column and line exist in this mode
  logic [7:0] scan_code;   // character code shown
  logic [4:0] glyph_dots;  // dots from the glyph lookup

  assign pos_sum     = {2'h0, scan.column} + shift_offset;
  assign pos_in_line = (pos_sum >= line_len) ? pos_sum - line_len : pos_sum;
  assign scan_addr   = ((mode == mode_2x12 && scan.line) ? `LINE2_BASE : 7'h00)
                     + pos_in_line;
  assign scan_ok     = (mode == mode_1x24) ? (scan.column < `SHOW_1X24 && !scan.line)
                     : (mode == mode_2x12) ? (scan.column < `SHOW_12)
                     : (scan.column < `SHOW_12 && !scan.line);
  assign scan_code   = character_store[scan_addr];

  glyph_fetch u_glyph_fetch
  (
    .code     (scan_code),
    .row      (scan.row),
    .user_row (user_glyph_store[{scan_code[3:0], scan.row}]),
    .dots     (glyph_dots)
  );

  // registered dots, blank outside the shown area
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      scan_dots <= 5'h00;
    else if (ce)
      scan_dots <= scan_ok ? glyph_dots : 5'h00;
  end

endmodule : char_ram_addressing

// ===== src/glyph_fetch.sv
// ----------------------------------------------------------------
// glyph lookup: user glyph store or fixed glyph store
// ----------------------------------------------------------------
module glyph_fetch
(
  // character and dot row being shown
  input  wire logic [7:0] code,
  input  wire logic [2:0] row,
  // row read from the user glyph store at {code[3:0], row}
  input  wire logic [4:0] user_row,
  // five dots, 1 lights the dot
  output logic      [4:0] dots
);

  logic [4:0] fixed_row;  // fixed glyph store output

  // stand-in pattern generator for the fixed store; rows 0 and 1
  // carry the code itself so all 240 codes give distinct glyphs,
  // a real font table drops in here without touching the ports
  always_comb
  begin
    unique case (row)
      3'h0:    fixed_row = code[7:3];
      3'h1:    fixed_row = {code[2:0], 2'h0};
      default: fixed_row = code[4:0] ^ {2'h0, row};
    endcase
  end

  // upper nibble zero selects the user store, else the fixed store
  always_comb
  begin
    if (code[7:4] == 4'h0)
      dots = user_row;
    else
      dots = fixed_row;
  end

endmodule : glyph_fetch

// ===== test/ahb_host.sv
`include "char_ram_map.svh"
// ------------------------------
// host model: single word transfers
// ------------------------------
module ahb_host
(
  // clock
  input  wire logic        clk,
  // request side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // answer side
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    hsel   = 1'b1;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = `HSIZE_WORD;
    hwdata = 32'h0;
  end

  // one transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (!hready)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hready)
      @(posedge clk);
    rd = hrdata;
    // stale data would hide a late sample
    hwdata <= ~wd;
  endtask : xfer

  // poll status until not busy
  task automatic idle();
    logic [31:0] s;
    s = 32'h80;
    while (s[`STAT_BUSY_BIT])
      xfer(1'b0, `OFS_STATUS, 32'h0, s);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] s;
    idle();
    xfer(1'b1, a, {24'h0, d}, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    idle();
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
endmodule : ahb_host

// ===== test/char_ram_addressing_asserts.sv
// ------------------------------
// bus and busy checker
// ------------------------------
module char_ram_addressing_asserts
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // status
  input  wire logic        busy_indicator,
  input  wire logic [2:0]  icon_glyph_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic dphase;  // any data phase in flight
  wire  taken = ce && hsel && hready && htrans[1] && hsize == 3'h2;

  // data phase tracker, held while the slave stretches
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dphase <= 1'b0;
    else if (ce && hready)
      dphase <= taken;
  end

  sequence rd_taken;
    taken && !hwrite;
  endsequence
  sequence stat_taken;
    taken && !hwrite && haddr[7:0] == 8'h00;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with error");
  a_read_wait: assert property (rd_taken |=> rd_wait)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stretched");
  a_busy_three: assert property ($rose(busy_indicator) |-> busy_indicator[*3] ##1 !busy_indicator)
    else $error("busy did not last three cycles");
  a_busy_cause: assert property ($rose(busy_indicator) |-> $past(dphase))
    else $error("busy rose without an instruction");
  a_status_busy: assert property (stat_taken |=> ##1 hrdata[7] == $past(busy_indicator))
    else $error("status top bit differs from busy");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_icon_count: assert property (icon_glyph_count inside {3'h0, 3'h3, 3'h6})
    else $error("icon glyph count illegal");
endmodule : char_ram_addressing_asserts

// ===== test/char_ram_addressing_tb_top.sv
`include "char_ram_map.svh"
module char_ram_addressing_tb_top import char_ram_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // nets and bookkeeping
  // ------------------------------
  logic        clk, reset_n, ce, hsel, hwrite, hreadyout, hresp, busy_indicator;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, icon_glyph_count;
  logic [4:0]  scan_dots;
  scan_s       scan;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // wrap table: mode and direction, start, byte, counter after
  typedef struct packed {logic [7:0] cfg; logic [6:0] at; logic [7:0] d; logic [6:0] nxt;} row_s;
  // mode code 3 falls back to one line; the last row leaves counter bit 6 clear
  row_s rows [9] = '{'{8'h00, 7'h4f, 8'h11, 7'h00}, '{8'h00, 7'h05, 8'h22, 7'h06},
                     '{8'h01, 7'h27, 8'h33, 7'h40}, '{8'h01, 7'h67, 8'h44, 7'h00},
                     '{8'h02, 7'h27, 8'h55, 7'h00}, '{8'h04, 7'h00, 8'h66, 7'h4f},
                     '{8'h03, 7'h4f, 8'h88, 7'h00}, '{8'h05, 7'h00, 8'h99, 7'h67},
                     '{8'h05, 7'h40, 8'h77, 7'h27}};
  logic [7:0] icfg [3] = '{8'h00, 8'h08, 8'h18};
  logic [7:0] icnt [3] = '{8'h00, 8'h03, 8'h06};

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  char_ram_addressing i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scan(scan), .scan_dots(scan_dots), .busy_indicator(busy_indicator),
    .icon_glyph_count(icon_glyph_count));

  ahb_host i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // ------------------------------
  // compare and closing tasks
  // ------------------------------
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t pin %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // scan one dot row, output lands one cycle later
  task automatic show(input logic l, input logic [4:0] c, input logic [2:0] r,
                      input logic [4:0] exp);
    scan <= {l, c, r};
    @(posedge clk);
    @(negedge clk);
    chk_pin({3'h0, scan_dots}, {3'h0, exp});
    @(posedge clk);
  endtask : show

  // hang guard, far above the expected run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    reset_n = 1'b0;
    ce      = 1'b1;
    scan    = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_pin({7'h0, busy_indicator}, 8'h00);
    chk_pin({5'h0, icon_glyph_count}, 8'h00);
    i_host.rd(`OFS_STATUS, q);
    chk_bus(q, 32'h0);
    // stepping and wrap per mode and direction, except one line of 12 stepping down
    foreach (rows[i])
    begin
      i_host.wr(`OFS_CONFIG, rows[i].cfg);
      i_host.wr(`OFS_COMMAND, {1'b1, rows[i].at});
      i_host.wr(`OFS_DATA, rows[i].d);
      i_host.rd(`OFS_STATUS, q);
      chk_bus(q, {25'h0, rows[i].nxt});
      i_host.wr(`OFS_COMMAND, {1'b1, rows[i].at});
      i_host.rd(`OFS_DATA, q);
      chk_bus(q, {24'h0, rows[i].d});
      i_host.rd(`OFS_STATUS, q);
      chk_bus(q, {25'h0, rows[i].nxt});
    end
    // icon glyph usage
    for (int k = 0; k < 3; k++)
    begin
      i_host.wr(`OFS_CONFIG, icfg[k]);
      i_host.rd(`OFS_STATUS, q);
      chk_pin({5'h0, icon_glyph_count}, icnt[k]);
    end
    // user glyph slot 1, then codes 01h and 10h on line one
    i_host.wr(`OFS_CONFIG, 8'h00);
    i_host.wr(`OFS_COMMAND, 8'h48);
    for (int r = 0; r < 8; r++)
      i_host.wr(`OFS_DATA, 8'h10 ^ 8'(r));
    i_host.wr(`OFS_COMMAND, 8'h80);
    i_host.wr(`OFS_DATA, 8'h01);
    i_host.wr(`OFS_DATA, 8'h10);
    for (int r = 0; r < 8; r++)
      show(1'b0, 5'h0, 3'(r), 5'h10 ^ 5'(r));
    show(1'b0, 5'h1, 3'h0, 5'h02);
    // outside the shown area of one line of 24 the dots stay dark
    show(1'b1, 5'h0, 3'h0, 5'h00);
    show(1'b0, 5'h18, 3'h0, 5'h00);
    // glyph address keeps counter bit 6, first clear then set
    i_host.wr(`OFS_COMMAND, 8'h80);
    i_host.wr(`OFS_COMMAND, 8'h45);
    i_host.rd(`OFS_STATUS, q);
    chk_bus(q, 32'h05);
    i_host.wr(`OFS_COMMAND, 8'hc0);
    i_host.wr(`OFS_COMMAND, 8'h45);
    i_host.rd(`OFS_STATUS, q);
    chk_bus(q, 32'h45);
    // second line wraps within itself on a right shift
    i_host.wr(`OFS_CONFIG, 8'h01);
    i_host.wr(`OFS_COMMAND, 8'he7);
    i_host.wr(`OFS_DATA, 8'h10);
    i_host.wr(`OFS_SHIFT, 8'h00);
    i_host.rd(`OFS_STATUS, q);
    show(1'b1, 5'h0, 3'h0, 5'h02);
    // data write during busy is dropped, no step
    i_host.wr(`OFS_COMMAND, 8'h90);
    @(negedge clk);
    chk_pin({7'h0, busy_indicator}, 8'h01);
    @(posedge clk);
    i_host.xfer(1'b1, `OFS_DATA, 32'h5a, q);
    i_host.rd(`OFS_STATUS, q);
    chk_bus(q, 32'h10);
    test_done();
  end
endmodule : char_ram_addressing_tb_top

bind char_ram_addressing char_ram_addressing_asserts i_chk (.clk(clk), .reset_n(reset_n),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .busy_indicator(busy_indicator), .icon_glyph_count(icon_glyph_count));
